// ==== core/rgo_defs.svh ====
// Constants of the right-half gain, offset and binning command interpreter
`ifndef RGO_DEFS_SVH
`define RGO_DEFS_SVH

// Command codes
`define RGO_CODE_GAIN    8'h82
`define RGO_CODE_OFFSET  8'h83
`define RGO_CODE_HBIN    8'ha3

// Data lengths carried by the commands
`define RGO_LEN_GAIN     7'h02
`define RGO_LEN_OFFSET   7'h02
`define RGO_LEN_HBIN     7'h01
`define RGO_LEN_NONE     7'h00

// Second header byte: direction flag on top, length below
`define RGO_FLAG_BIT     7
`define RGO_FLAG_READ    1'b1
`define RGO_FLAG_WRITE   1'b0

// Binning encodings
`define RGO_HBIN_OFF     8'h00
`define RGO_HBIN_ON      8'h01

// Reset values of the settings
`define RGO_GAIN_RST     16'h0120
`define RGO_OFFSET_RST   16'h0000
`define RGO_HBIN_RST     1'b0

// Response byte positions
`define RGO_IDX_CODE     2'h0
`define RGO_IDX_HDR      2'h1
`define RGO_IDX_LO       2'h2
`define RGO_IDX_HI       2'h3

// APB register byte addresses
`define RGO_ADDR_CTRL    12'h000
`define RGO_ADDR_GAIN    12'h004
`define RGO_ADDR_OFFSET  12'h008
`define RGO_ADDR_HBIN    12'h00c
`define RGO_ADDR_STATUS  12'h010

// Control register fields
`define RGO_CTRL_EN      0
`define RGO_CTRL_CLR     1
`define RGO_CTRL_RST     1'b1

`endif

// ==== core/rgo_pkg.sv ====
// Types shared by the command interpreter and its response sender
package rgo_pkg;

    // Parser states
    typedef enum logic [1:0] {
        RGO_ST_CODE = 2'b00,
        RGO_ST_HDR  = 2'b01,
        RGO_ST_DATA = 2'b10,
        RGO_ST_RESP = 2'b11
    } rgo_state_e;

    // One response frame
    typedef struct packed {
        logic [7:0]  code;
        logic [6:0]  len;
        logic [15:0] data;
    } rgo_rsp_s;

endpackage : rgo_pkg

// ==== core/rgo_responder.sv ====
// Serialises one read response frame onto the outgoing byte stream
`timescale 1ns/1ps
`include "rgo_defs.svh"

module rgo_responder
    import rgo_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic load,
    input wire rgo_rsp_s rsp,
    input wire logic tx_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    output logic busy
);

    rgo_rsp_s frame;
    rgo_rsp_s next_frame;
    logic [1:0] idx;
    logic [1:0] next_idx;
    logic next_tx_valid;
    logic [7:0] next_tx_data;
    logic next_busy;

    // Byte at a frame position; data goes low byte first
    function automatic logic [7:0] pick(input rgo_rsp_s f, input logic [1:0] i);
        if (i == `RGO_IDX_CODE) begin
            pick = f.code;
        end else if (i == `RGO_IDX_HDR) begin
            pick = {`RGO_FLAG_WRITE, f.len};
        end else if (i == `RGO_IDX_LO) begin
            pick = f.data[7:0];
        end else begin
            pick = f.data[15:8];
        end
    endfunction : pick

    // Step to the next byte on each accepted one; last byte is header plus len
    always_comb begin
        next_frame = frame;
        next_idx = idx;
        next_tx_valid = tx_valid;
        next_tx_data = tx_data;
        next_busy = busy;
        if (load && !busy) begin
            next_frame = rsp;
            next_idx = `RGO_IDX_CODE;
            next_tx_valid = 1'b1;
            next_tx_data = pick(rsp, `RGO_IDX_CODE);
            next_busy = 1'b1;
        end else if (tx_valid && tx_ready) begin
            if ({6'h00, idx} == {1'b0, frame.len} + 8'h01) begin
                next_tx_valid = 1'b0;
                next_busy = 1'b0;
            end else begin
                next_idx = idx + 2'h1;
                next_tx_data = pick(frame, idx + 2'h1);
            end
        end
    end

    // Registers of the sender
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            frame <= '0;
            idx <= `RGO_IDX_CODE;
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            busy <= 1'b0;
        end else begin
            frame <= next_frame;
            idx <= next_idx;
            tx_valid <= next_tx_valid;
            tx_data <= next_tx_data;
            busy <= next_busy;
        end
    end

endmodule : rgo_responder

// ==== core/rgo_cmd.sv ====
// Command interpreter for right-half gain, right-half offset and horizontal binning
// What this block does
// - Gain read, code 0x82 flag 1 length 2, answers code, flag 0, two bytes.
// - Gain write, code 0x82 flag 0 length 2, stores value, sends nothing.
// - Gain bytes travel low byte first, then high byte.
// - Offset read, code 0x83 flag 1 length 2, answers code, flag 0, two bytes.
// - Offset write, code 0x83 flag 0 length 2, stores value, sends nothing.
// - Offset bytes travel low byte first, then high byte.
// - Binning code 0xa3 length 1: read answers one byte, write answers nothing.
// - Binning byte 0x00 means off, 0x01 means on, reported the same way.
//
// Chosen here: register access over APB and the address map.
`timescale 1ns/1ps
`include "rgo_defs.svh"

module rgo_cmd
    import rgo_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    output logic rx_ready,
    output logic tx_valid,
    output logic [7:0] tx_data,
    input wire logic tx_ready,
    output logic [15:0] gain,
    output logic [15:0] offset,
    output logic hbin_enable
);

    rgo_state_e state;
    rgo_state_e next_state;
    logic [7:0] code;
    logic [7:0] next_code;
    logic [6:0] len;
    logic [6:0] next_len;
    logic [6:0] cnt;
    logic [6:0] next_cnt;
    logic [7:0] low_byte;
    logic [7:0] next_low_byte;
    logic discard;
    logic next_discard;
    logic [15:0] next_gain;
    logic [15:0] next_offset;
    logic next_hbin_enable;
    logic [7:0] err_cnt;
    logic [7:0] next_err_cnt;
    logic rsp_go;
    logic next_rsp_go;
    rgo_rsp_s rsp;
    rgo_rsp_s next_rsp;
    logic next_rx_ready;
    logic ctrl_en;
    logic next_ctrl_en;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic take;
    logic err_event;
    logic clr_err;
    logic tx_busy;

    // Length that a known command carries; unknown codes give none
    function automatic logic [6:0] expect_len(input logic [7:0] c);
        if (c == `RGO_CODE_GAIN) begin
            expect_len = `RGO_LEN_GAIN;
        end else if (c == `RGO_CODE_OFFSET) begin
            expect_len = `RGO_LEN_OFFSET;
        end else if (c == `RGO_CODE_HBIN) begin
            expect_len = `RGO_LEN_HBIN;
        end else begin
            expect_len = `RGO_LEN_NONE;
        end
    endfunction : expect_len

    assign take = rx_valid && rx_ready;

    // Frame parser and settings
    always_comb begin
        next_state = state;
        next_code = code;
        next_len = len;
        next_cnt = cnt;
        next_low_byte = low_byte;
        next_discard = discard;
        next_gain = gain;
        next_offset = offset;
        next_hbin_enable = hbin_enable;
        next_rsp_go = 1'b0;
        next_rsp = rsp;
        err_event = 1'b0;
        case (state)
            RGO_ST_CODE: begin
                if (take) begin
                    next_code = rx_data;
                    next_state = RGO_ST_HDR;
                end
            end
            RGO_ST_HDR: begin
                if (take) begin
                    next_len = rx_data[6:0];
                    next_cnt = 7'h00;
                    next_discard = (expect_len(code) == `RGO_LEN_NONE)
                        || (rx_data[6:0] != expect_len(code));
                    if (next_discard) begin
                        err_event = 1'b1;
                    end
                    if (rx_data[`RGO_FLAG_BIT] == `RGO_FLAG_READ) begin
                        // Reads carry no data; only a well-formed one is answered
                        if (next_discard) begin
                            next_state = RGO_ST_CODE;
                        end else begin
                            next_rsp.code = code;
                            next_rsp.len = expect_len(code);
                            if (code == `RGO_CODE_GAIN) begin
                                next_rsp.data = gain;
                            end else if (code == `RGO_CODE_OFFSET) begin
                                next_rsp.data = offset;
                            end else begin
                                next_rsp.data = {8'h00, hbin_enable ? `RGO_HBIN_ON
                                    : `RGO_HBIN_OFF};
                            end
                            next_rsp_go = 1'b1;
                            next_state = RGO_ST_RESP;
                        end
                    end else if (rx_data[6:0] == `RGO_LEN_NONE) begin
                        next_state = RGO_ST_CODE;
                    end else begin
                        next_state = RGO_ST_DATA;
                    end
                end
            end
            RGO_ST_DATA: begin
                // Bad writes still swallow their data bytes to stay in frame
                if (take) begin
                    next_cnt = cnt + 7'h01;
                    if (cnt == 7'h00) begin
                        next_low_byte = rx_data;
                    end
                    if (next_cnt == len) begin
                        next_state = RGO_ST_CODE;
                        if (!discard) begin
                            if (code == `RGO_CODE_GAIN) begin
                                next_gain = {rx_data, low_byte};
                            end else if (code == `RGO_CODE_OFFSET) begin
                                next_offset = {rx_data, low_byte};
                            end else if (rx_data == `RGO_HBIN_ON) begin
                                next_hbin_enable = 1'b1;
                            end else if (rx_data == `RGO_HBIN_OFF) begin
                                next_hbin_enable = 1'b0;
                            end else begin
                                err_event = 1'b1;
                            end
                        end
                    end
                end
            end
            RGO_ST_RESP: begin
                // Input held off until the whole response has left
                if (!rsp_go && !tx_busy) begin
                    next_state = RGO_ST_CODE;
                end
            end
            default: begin
                next_state = RGO_ST_CODE;
            end
        endcase
        next_rx_ready = ctrl_en && (next_state != RGO_ST_RESP);
    end

    // Error counter: a clear in the same cycle as a new error leaves a count of one
    always_comb begin
        if (clr_err) begin
            next_err_cnt = {7'h00, err_event};
        end else if (err_event && err_cnt != 8'hff) begin
            next_err_cnt = err_cnt + 8'h01;
        end else begin
            next_err_cnt = err_cnt;
        end
    end

    // Parser registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= RGO_ST_CODE;
            code <= 8'h00;
            len <= `RGO_LEN_NONE;
            cnt <= 7'h00;
            low_byte <= 8'h00;
            discard <= 1'b0;
            gain <= `RGO_GAIN_RST;
            offset <= `RGO_OFFSET_RST;
            hbin_enable <= `RGO_HBIN_RST;
            err_cnt <= 8'h00;
            rsp_go <= 1'b0;
            rsp <= '0;
            rx_ready <= 1'b0;
        end else begin
            state <= next_state;
            code <= next_code;
            len <= next_len;
            cnt <= next_cnt;
            low_byte <= next_low_byte;
            discard <= next_discard;
            gain <= next_gain;
            offset <= next_offset;
            hbin_enable <= next_hbin_enable;
            err_cnt <= next_err_cnt;
            rsp_go <= next_rsp_go;
            rsp <= next_rsp;
            rx_ready <= next_rx_ready;
        end
    end

    // Read responses go out through a separate sender
    rgo_responder u_responder (
        .pclk(pclk),
        .presetn(presetn),
        .load(rsp_go),
        .rsp(rsp),
        .tx_ready(tx_ready),
        .tx_valid(tx_valid),
        .tx_data(tx_data),
        .busy(tx_busy)
    );

    // APB slave: one wait state so that read data and pready come from flops
    always_comb begin
        next_pready = psel && penable && !pready;
        next_prdata = prdata;
        next_pslverr = 1'b0;
        next_ctrl_en = ctrl_en;
        clr_err = 1'b0;
        if (next_pready) begin
            next_prdata = 32'h0000_0000;
            if (paddr == `RGO_ADDR_CTRL) begin
                next_prdata[`RGO_CTRL_EN] = ctrl_en;
            end else if (paddr == `RGO_ADDR_GAIN) begin
                next_prdata[15:0] = gain;
            end else if (paddr == `RGO_ADDR_OFFSET) begin
                next_prdata[15:0] = offset;
            end else if (paddr == `RGO_ADDR_HBIN) begin
                next_prdata[0] = hbin_enable;
            end else if (paddr == `RGO_ADDR_STATUS) begin
                next_prdata = {21'h000000, tx_busy, state, err_cnt};
            end else begin
                next_pslverr = 1'b1;
            end
        end
        // Control write lands on the edge that completes the transfer, not a cycle early
        if (psel && penable && pready && pwrite && (paddr == `RGO_ADDR_CTRL)) begin
            next_ctrl_en = pwdata[`RGO_CTRL_EN];
            clr_err = pwdata[`RGO_CTRL_CLR];
        end
    end

    // APB registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
            ctrl_en <= `RGO_CTRL_RST;
        end else begin
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
            ctrl_en <= next_ctrl_en;
        end
    end

endmodule : rgo_cmd

// ==== verif/rgo_cmd_monitor.sv ====
// Concurrent checks on the ports of the command interpreter
`timescale 1ns/1ps

module rgo_cmd_monitor
    import rgo_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic rx_valid,
    input wire logic [7:0] rx_data,
    input wire logic rx_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    input wire logic tx_ready,
    input wire logic [15:0] gain,
    input wire logic [15:0] offset,
    input wire logic hbin_enable
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Last response byte handed over, sender idle right after
    sequence tx_last;
        tx_valid && tx_ready ##1 !tx_valid;
    endsequence

    // One wait state, then a single-cycle answer
    sequence apb_answer;
        pready ##1 !pready;
    endsequence

    rsp_lat_a: assert property (
        $rose(tx_valid) |-> $past(rx_valid && rx_ready, 2))
        else $error("response did not follow a header");
    rsp_code_a: assert property (
        $rose(tx_valid) |-> tx_data inside {8'h82, 8'h83, 8'ha3})
        else $error("response opened with a wrong code");
    tx_hold_a: assert property (
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("response byte dropped before taken");
    rx_pause_a: assert property (tx_valid |-> !rx_ready)
        else $error("intake open during a response");
    // Bounded wait keeps the reopening check able to fail
    rx_back_a: assert property (tx_last |-> !rx_ready ##[1:3] rx_ready)
        else $error("intake did not reopen after a response");
    set_src_a: assert property (
        $changed(gain) || $changed(offset) |-> $past(rx_valid && rx_ready))
        else $error("setting changed without a byte taken");
    bin_on_a: assert property (
        $rose(hbin_enable) |-> $past(rx_valid && rx_ready && rx_data == 8'h01))
        else $error("binning enabled without byte 0x01");
    bin_off_a: assert property (
        $fell(hbin_enable) |-> $past(rx_valid && rx_ready && rx_data == 8'h00))
        else $error("binning disabled without byte 0x00");
    apb_wait_a: assert property (psel && penable && !pready |=> apb_answer)
        else $error("register read answer out of time");
endmodule : rgo_cmd_monitor

bind rgo_cmd rgo_cmd_monitor mon_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pready(pready), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .gain(gain), .offset(offset), .hbin_enable(hbin_enable));

// ==== verif/rgo_host_model.sv ====
// Host model: sends command frames and collects response bytes
`timescale 1ns/1ps

module rgo_host_model (
    input wire logic pclk,
    output logic rx_valid,
    output logic [7:0] rx_data,
    input wire logic rx_ready,
    input wire logic tx_valid,
    input wire logic [7:0] tx_data,
    output logic tx_ready
);
    logic slow = 1'b0;
    logic [7:0] got [$];

    initial begin
        rx_valid = 1'b0;
        rx_data = 8'h00;
        tx_ready = 1'b1;
    end

    // Collect response bytes; a slow sink stalls every other cycle
    always @(posedge pclk) begin
        if (tx_valid && tx_ready) begin
            got.push_back(tx_data);
        end
        tx_ready <= slow ? ~tx_ready : 1'b1;
    end

    // Offer one byte and hold it until the edge that takes it
    task automatic send_byte(input logic [7:0] b);
        rx_valid <= 1'b1;
        rx_data <= b;
        @(posedge pclk);
        while (rx_ready !== 1'b1) begin
            @(posedge pclk);
        end
    endtask : send_byte

    // Whole frame, data low byte first; released line shows a flipped value
    task automatic send_frame(input logic [7:0] code, input logic [7:0] hdr,
                              input logic [15:0] d, input int n);
        send_byte(code);
        send_byte(hdr);
        if (n > 0) send_byte(d[7:0]);
        if (n > 1) send_byte(d[15:8]);
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
        @(posedge pclk);
    endtask : send_frame
endmodule : rgo_host_model

// ==== verif/tb_top.sv ====
// Testbench of the command interpreter with host model and register master
`timescale 1ns/1ps

`define CHK(a, b) begin compares++; if ((a) !== (b)) begin failures++; \
    $display("ERROR %0t got %h expected %h", $time, (a), (b)); end end

module tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata, rd;
    logic pready, pslverr, rx_valid, rx_ready, tx_valid, tx_ready, hbin_enable, err;
    logic [7:0] rx_data, tx_data;
    logic [15:0] gain, offset;
    int failures = 0;
    int compares = 0;

    always #20 pclk = ~pclk;

    rgo_cmd dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
        .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready), .gain(gain),
        .offset(offset), .hbin_enable(hbin_enable));

    rgo_host_model host_u (.pclk(pclk), .rx_valid(rx_valid), .rx_data(rx_data),
        .rx_ready(rx_ready), .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready));

    // One transfer; an idle edge after it keeps drivers single per step
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    // Write a setting, then see it on the level output, the register and a read frame
    task automatic t_setting(input logic [7:0] code, input logic [11:0] a, input logic [15:0] v);
        int n;
        logic [15:0] now_val;
        n = (code == 8'ha3) ? 3 : 4;
        host_u.send_frame(code, {1'b0, 7'(n - 2)}, v, n - 2);
        @(posedge pclk);
        now_val = code == 8'h82 ? gain : code == 8'h83 ? offset : {15'h0000, hbin_enable};
        `CHK(now_val, v)
        apb(1'b0, a, 32'h00000000);
        `CHK(rd[15:0], v)
        host_u.got.delete();
        host_u.send_frame(code, {1'b1, 7'(n - 2)}, 16'h0000, 0);
        for (int i = 0; i < 60 && host_u.got.size() < n; i++) @(posedge pclk);
        `CHK(host_u.got.size(), n)
        `CHK(host_u.got[0], code)
        `CHK(host_u.got[1], {1'b0, 7'(n - 2)})
        `CHK(host_u.got[2], v[7:0])
        if (n == 4) `CHK(host_u.got[3], v[15:8])
    endtask : t_setting

    // Values after reset, and an unmapped register refused
    task automatic t_reset();
        `CHK({gain, offset, hbin_enable}, {16'h0120, 16'h0000, 1'b0})
        apb(1'b0, 12'h000, 32'h00000000);
        `CHK(rd, 32'h00000001)
        apb(1'b0, 12'h014, 32'h00000000);
        `CHK({err, rd}, {1'b1, 32'h00000000})
    endtask : t_reset

    // Gain at both ends of the host's range, slow sink
    task automatic t_gain();
        host_u.slow = 1'b1;
        t_setting(8'h82, 12'h004, 16'h0239);
        t_setting(8'h82, 12'h004, 16'h0120);
    endtask : t_gain

    // Offset at both ends of the host's range, prompt sink
    task automatic t_offset();
        host_u.slow = 1'b0;
        t_setting(8'h83, 12'h008, 16'h00ff);
        t_setting(8'h83, 12'h008, 16'h0000);
    endtask : t_offset

    // Both binning codes
    task automatic t_bin();
        t_setting(8'ha3, 12'h00c, 16'h0001);
        t_setting(8'ha3, 12'h00c, 16'h0000);
    endtask : t_bin

    // Unknown code and bad binning byte dropped and counted, then intake stopped
    task automatic t_refuse();
        host_u.got.delete();
        host_u.send_frame(8'h84, 8'h81, 16'h0000, 0);
        host_u.send_frame(8'ha3, 8'h01, 16'h0002, 1);
        repeat (4) @(posedge pclk);
        `CHK({hbin_enable, host_u.got.size()}, {1'b0, 32'h00000000})
        apb(1'b0, 12'h010, 32'h00000000);
        `CHK(rd[7:0], 8'h02)
        apb(1'b1, 12'h000, 32'h00000003);
        apb(1'b0, 12'h010, 32'h00000000);
        `CHK(rd[7:0], 8'h00)
        apb(1'b1, 12'h000, 32'h00000000);
        @(posedge pclk);
        `CHK(rx_ready, 1'b0)
        apb(1'b1, 12'h000, 32'h00000001);
    endtask : t_refuse

    // Single exit for the normal end and the watchdog
    task automatic complete_run();
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_gain();
        t_offset();
        t_bin();
        t_refuse();
        complete_run();
    end

    // Whole run needs well under 1000 cycles
    initial begin
        #200000;
        failures++;
        complete_run();
    end
endmodule : tb_top
